// [logic/pld_fuse_and_matrix.sv]
// fuse-programmed AND matrix, product-term output stage and fuse-selected mux
// assumes pins come from outside the aclk domain and software uses AXI4-Lite
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "pld_fuse_map.svh"

module pld_fuse_and_matrix #(
   parameter int                N_IN      = 12,
   parameter int                N_OUT     = 8,
   parameter int                MUX_N     = 4,
   parameter int                FUSE_W    = 1024,
   parameter logic [FUSE_W-1:0] FUSE_MAP  = '0,
   parameter int                EN_FUSE0  = 960,
   parameter int                POL_FUSE  = 968,
   parameter int                SEL_FUSE0 = 1000,
   parameter int                MUX_POL   = 1023
) (
   // clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // axi4-lite write address
   input  wire logic                s_axi_awvalid,
   output      logic                s_axi_awready,
   input  wire logic [7:0]          s_axi_awaddr,
   // axi4-lite write data
   input  wire logic                s_axi_wvalid,
   output      logic                s_axi_wready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   // axi4-lite write response
   output      logic                s_axi_bvalid,
   input  wire logic                s_axi_bready,
   output      logic [1:0]          s_axi_bresp,
   // axi4-lite read address
   input  wire logic                s_axi_arvalid,
   output      logic                s_axi_arready,
   input  wire logic [7:0]          s_axi_araddr,
   // axi4-lite read data
   output      logic                s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output      logic [31:0]         s_axi_rdata,
   output      logic [1:0]          s_axi_rresp,
   // array pins
   input  wire logic [N_IN-1:0]     data_in,
   input  wire logic [MUX_N-1:0]    mux_in,
   output      logic [N_OUT-1:0]    product_out,
   output      logic                expr_out,
   output      logic                mux_out
);

   localparam int IW  = 2 * N_IN;
   localparam int SW  = (MUX_N > 1) ? $clog2(MUX_N) : 1;
   localparam int LW  = (N_OUT > 1) ? $clog2(N_OUT) : 1;

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [N_IN-1:0]  din_meta_q;
   logic [N_IN-1:0]  din_q;
   logic [MUX_N-1:0] mux_meta_q;
   logic [MUX_N-1:0] mux_sync_q;

   // no reset on the sync flops: pins hold no state, and two edges flush them
   always_ff @(posedge aclk) begin
      din_meta_q <= data_in;
      din_q      <= din_meta_q;
      mux_meta_q <= mux_in;
      mux_sync_q <= mux_meta_q;
   end

   // ****************************************
   // registers
   // ****************************************
   pld_fuse_pkg::ctrl_t ctrl_q;
   logic [15:0]         base_q;
   logic [15:0]         step_q;
   logic [15:0]         first_q [N_OUT];

   logic                wr_go;
   logic [5:0]          wr_word;
   logic                wr_hit;
   logic [31:0]         wr_mask;

   // address and data are taken together, so neither half of a write waits alone
   // a response still waiting refuses the next write: one write under way at most
   assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_wready  = s_axi_awready;
   assign wr_go         = s_axi_awready;
   assign wr_word       = s_axi_awaddr[7:2];

   // one mask bit per data bit, spread from the byte strobes
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wr_mask[8*b +: 8] = {8{s_axi_wstrb[b]}};
      end
   end

   // fuse values themselves stay fixed; only numbering and mode are live
   // byte lanes are honoured on the 16-bit registers; control needs lane zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= '{step_assigned: 1'b0,
                     complement_mode_setting: pld_fuse_pkg::MODE_NONE};
         base_q <= `BASE_RESET;
         step_q <= `STEP_RESET;
      end else if (wr_go) begin
         if (wr_word == 6'(`CTRL_OFFSET >> 2) && s_axi_wstrb[0]) begin
            ctrl_q.complement_mode_setting <= pld_fuse_pkg::complement_mode_t'(
               s_axi_wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
            ctrl_q.step_assigned <= s_axi_wdata[`CTRL_STEP_SET_BIT];
         end
         if (wr_word == 6'(`BASE_OFFSET >> 2)) begin
            base_q <= (base_q & ~wr_mask[15:0]) | (s_axi_wdata[15:0] & wr_mask[15:0]);
         end
         if (wr_word == 6'(`STEP_OFFSET >> 2)) begin
            step_q <= (step_q & ~wr_mask[15:0]) | (s_axi_wdata[15:0] & wr_mask[15:0]);
         end
      end
   end

   // per-line first fuse, zero until assigned
   generate
      for (genvar n = 0; n < N_OUT; n++) begin : g_first
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               first_q[n] <= `FIRST_RESET;
            end else if (wr_go && wr_word == 6'((`FIRST_OFFSET >> 2) + n)) begin
               first_q[n] <= (first_q[n] & ~wr_mask[15:0])
                           | (s_axi_wdata[15:0] & wr_mask[15:0]);
            end
         end
      end
   endgenerate

   // ****************************************
   // write decode and response
   // ****************************************
   always_comb begin
      wr_hit = (wr_word == 6'(`CTRL_OFFSET >> 2)) || (wr_word == 6'(`BASE_OFFSET >> 2))
            || (wr_word == 6'(`STEP_OFFSET >> 2))
            || (wr_word >= 6'(`FIRST_OFFSET >> 2)
                && wr_word < 6'((`FIRST_OFFSET >> 2) + N_OUT));
   end

   // bresp loads only when a write is taken, so it stands as long as bvalid
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ****************************************
   // internal word
   // ****************************************
   logic [IW-1:0] word;
   // numbering width: the input count, doubled in either complement mode
   logic [15:0]   width;

   // plus and minus differ only in which of each pair carries the inverse
   always_comb begin
      word  = '0;
      width = 16'(IW);
      unique case (ctrl_q.complement_mode_setting)
         pld_fuse_pkg::MODE_PLUS: begin
            for (int i = 0; i < N_IN; i++) begin
               word[2*i]   = din_q[i];
               word[2*i+1] = !din_q[i];
            end
         end
         pld_fuse_pkg::MODE_MINUS: begin
            for (int i = 0; i < N_IN; i++) begin
               word[2*i]   = !din_q[i];
               word[2*i+1] = din_q[i];
            end
         end
         // the spare code falls back to no complement rather than an undefined word
         pld_fuse_pkg::MODE_NONE, pld_fuse_pkg::MODE_SPARE: begin
            word[N_IN-1:0] = din_q;
            width          = 16'(N_IN);
         end
      endcase
   end

   // ****************************************
   // and matrix
   // ****************************************
   // fuses past the end of the map count as blown so a bad base cannot hang a line low
   function automatic logic fuse_at(input int idx);
      fuse_at = (idx < FUSE_W) ? FUSE_MAP[idx] : 1'b1;
   endfunction

   // the first fuse in use per line; software reads this value back
   logic [15:0] first_fuse [N_OUT];

   // one product line per output, each reading its own window of the map
   generate
      for (genvar n = 0; n < N_OUT; n++) begin : g_line
         always_comb begin
            int start;
            start = 0;
            if (ctrl_q.step_assigned) begin
               first_fuse[n] = 16'(base_q + 16'(n) * step_q);
            end else begin
               first_fuse[n] = first_q[n];
            end
            start = int'(first_fuse[n]);
            // a line with every fuse blown reads active: an and of nothing
            product_out[n] = 1'b1;
            for (int j = 0; j < IW; j++) begin
               // fuse zero keeps the input on the line
               if (j < int'(width) && !fuse_at(start + j) && !word[j]) begin
                  product_out[n] = 1'b0;
               end
            end
         end
      end
   endgenerate

   // ****************************************
   // product-term output stage
   // ****************************************
   // enable fuse one lets a term through; polarity fuse one inverts the or
   always_comb begin
      logic any;
      any = 1'b0;
      for (int n = 0; n < N_OUT; n++) begin
         any = any | (product_out[n] & fuse_at(EN_FUSE0 + n));
      end
      expr_out = any ^ fuse_at(POL_FUSE);
   end

   // ****************************************
   // fuse-selected multiplexer
   // ****************************************
   logic [SW-1:0] mux_sel;
   // select bit zero is least significant; fuses fix the choice once loaded

   generate
      for (genvar k = 0; k < SW; k++) begin : g_sel
         assign mux_sel[k] = fuse_at(SEL_FUSE0 + k);
      end
   endgenerate

   // no register in this path: selector adds no delay beyond the pin sync
   assign mux_out = mux_sync_q[mux_sel] ^ fuse_at(MUX_POL);

   // ****************************************
   // read channel
   // ****************************************
   logic [5:0]    rd_word;
   logic [31:0]   rd_data;
   logic          rd_hit;
   logic [LW-1:0] rd_line;

   assign rd_word       = s_axi_araddr[7:2];
   assign rd_line       = LW'(rd_word - 6'(`FIRST_OFFSET >> 2));
   assign s_axi_arready = !s_axi_rvalid;

   // status is a snapshot taken at the edge that accepts the address
   always_comb begin
      rd_data = '0;
      rd_hit  = 1'b1;
      if (rd_word == 6'(`CTRL_OFFSET >> 2)) begin
         rd_data[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = ctrl_q.complement_mode_setting;
         rd_data[`CTRL_STEP_SET_BIT]            = ctrl_q.step_assigned;
      end else if (rd_word == 6'(`BASE_OFFSET >> 2)) begin
         rd_data[15:0] = base_q;
      end else if (rd_word == 6'(`STEP_OFFSET >> 2)) begin
         rd_data[15:0] = step_q;
      end else if (rd_word == 6'(`STATUS_OFFSET >> 2)) begin
         rd_data[N_OUT-1:0]       = product_out;
         rd_data[`STATUS_EXPR_BIT] = expr_out;
         rd_data[`STATUS_MUX_BIT]  = mux_out;
      end else if (rd_word >= 6'(`FIRST_OFFSET >> 2)
                   && rd_word < 6'((`FIRST_OFFSET >> 2) + N_OUT)) begin
         rd_data[15:0] = first_fuse[rd_line];
      end else begin
         rd_hit = 1'b0;
      end
   end

   // ****************************************
   // read response
   // ****************************************
   // rdata loads only on acceptance, so it stands as long as rvalid
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_data;
         s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// [logic/pld_fuse_map.svh]
// register offsets, field positions, reset values and bus answers
// assumes a 32-bit AXI4-Lite register bus and a fuse map given as a parameter
`ifndef PLD_FUSE_MAP_SVH
`define PLD_FUSE_MAP_SVH

// ****************************************
// register byte offsets
// ****************************************
`define CTRL_OFFSET        8'h00
`define BASE_OFFSET        8'h04
`define STEP_OFFSET        8'h08
`define STATUS_OFFSET      8'h0C
`define FIRST_OFFSET       8'h40

// ****************************************
// control fields
// ****************************************
`define CTRL_MODE_LSB      0
`define CTRL_MODE_MSB      1
`define CTRL_STEP_SET_BIT  4

// ****************************************
// status fields
// ****************************************
`define STATUS_EXPR_BIT    8
`define STATUS_MUX_BIT     9

// ****************************************
// reset values
// ****************************************
`define BASE_RESET         16'h0000
`define STEP_RESET         16'h000C
`define FIRST_RESET        16'h0000

// ****************************************
// bus answers
// ****************************************
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// [logic/pld_fuse_pkg.sv]
// types shared by the fuse array logic
// assumes nothing of its surroundings
package pld_fuse_pkg;

   // complement mode setting; code 3 is treated as none
   typedef enum logic [1:0] {
      MODE_NONE,
      MODE_PLUS,
      MODE_MINUS,
      MODE_SPARE
   } complement_mode_t;

   typedef struct packed {
      logic             step_assigned;
      complement_mode_t complement_mode_setting;
   } ctrl_t;

endpackage

// [sim/pld_fuse_and_matrix_assertions.sv]
// bus handshake and selector path checks for the fuse array
// assumes binding into every pld_fuse_and_matrix, one aclk domain
`timescale 1ns/1ps
module pld_fuse_and_matrix_checker #(
   parameter int                MUX_N     = 4,
   parameter int                FUSE_W    = 1024,
   parameter logic [FUSE_W-1:0] FUSE_MAP  = '0,
   parameter int                SEL_FUSE0 = 1000,
   parameter int                MUX_POL   = 1023
) (
   // clock and reset
   input wire logic             aclk,
   input wire logic             aresetn,
   // write side
   input wire logic             s_axi_awvalid,
   input wire logic             s_axi_awready,
   input wire logic [7:0]       s_axi_awaddr,
   input wire logic             s_axi_wvalid,
   input wire logic             s_axi_wready,
   input wire logic             s_axi_bvalid,
   input wire logic             s_axi_bready,
   input wire logic [1:0]       s_axi_bresp,
   // read side
   input wire logic             s_axi_arvalid,
   input wire logic             s_axi_arready,
   input wire logic [7:0]       s_axi_araddr,
   input wire logic             s_axi_rvalid,
   input wire logic             s_axi_rready,
   input wire logic [31:0]      s_axi_rdata,
   input wire logic [1:0]       s_axi_rresp,
   // selector
   input wire logic [MUX_N-1:0] mux_in,
   input wire logic             mux_out
);
   // ****************************************
   // helpers
   // ****************************************
   function automatic int sel_f();
      int s = 0;
      for (int k = 0; k < $clog2(MUX_N); k++) s |= int'(FUSE_MAP[SEL_FUSE0 + k]) << k;
      return s;
   endfunction
   localparam int SEL = sel_f();
   logic [1:0] up_q;
   logic       bad_w;
   logic       bad_r;
   // pins pass two sync flops, so the selector is judged only once they hold fresh values
   always_ff @(posedge aclk) begin
      if (!aresetn) up_q <= 2'h0;
      else if (up_q != 2'h3) up_q <= up_q + 2'h1;
   end
   assign bad_w = (s_axi_awaddr > 8'h0C && s_axi_awaddr < 8'h40) || s_axi_awaddr > 8'h5C;
   assign bad_r = (s_axi_araddr > 8'h0C && s_axi_araddr < 8'h40) || s_axi_araddr > 8'h5C;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   aw_ready_rule_a: assert property (s_axi_awready ==
      (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)) else $error("awready wrong");
   w_ready_match_a: assert property (s_axi_wready == s_axi_awready) else $error("wready wrong");
   b_follows_a: assert property (s_axi_awready |=> s_axi_bvalid) else $error("no bvalid");
   b_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
   b_clears_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid stuck");
   r_follows_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no rvalid");
   r_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   ar_refused_a: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
   bad_write_a: assert property (s_axi_awready && bad_w |=> s_axi_bresp == 2'h2)
      else $error("unmapped write not refused");
   bad_read_a: assert property (s_axi_arvalid && s_axi_arready && bad_r |=>
      s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
   mux_path_a: assert property (up_q == 2'h3 && $stable(mux_in) [*3] |->
      mux_out == (mux_in[SEL] ^ FUSE_MAP[MUX_POL])) else $error("selector output wrong");
endmodule

bind pld_fuse_and_matrix pld_fuse_and_matrix_checker #(.MUX_N(MUX_N), .FUSE_W(FUSE_W),
   .FUSE_MAP(FUSE_MAP), .SEL_FUSE0(SEL_FUSE0), .MUX_POL(MUX_POL)) chk_i (.aclk(aclk),
   .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .mux_in(mux_in), .mux_out(mux_out));

// [sim/tb.sv]
// self-checking bench: registers, product terms, output stage and selector
// assumes the design and checker files are compiled ahead of it
`timescale 1ns/1ps
`include "pld_fuse_map.svh"
module tb;
   // ****************************************
   // fuse map and expectations
   // ****************************************
   function automatic logic [1023:0] mk_map();
      logic [1023:0] m;
      m = '1;
      m[191:0] = {3{64'hF7ED_BFE7_FBDE_F7BF}};
      m[23:12] = 12'hEEA;
      m[968:960] = 9'h1A5;
      m[1001:1000] = 2'h2;
      return m;
   endfunction
   localparam logic [1023:0] FMAP = mk_map();
   function automatic logic [7:0] exp_prod(int mode, int first[8], logic [11:0] d);
      logic [23:0] iw;
      int          w;
      int          idx;
      exp_prod = '1;
      w = (mode == 1 || mode == 2) ? 24 : 12;
      for (int k = 0; k < 12; k++) begin
         if (w == 12) iw[k] = d[k];
         else begin
            iw[2*k] = d[k] ^ (mode == 2);
            iw[2*k+1] = ~iw[2*k];
         end
      end
      for (int n = 0; n < 8; n++)
         for (int j = 0; j < w; j++) begin
            idx = first[n] + j;
            if (idx < 1024 && !FMAP[idx]) exp_prod[n] &= iw[j];
         end
   endfunction
   logic        aclk = 1'b0;
   logic        aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, expr_out, mux_out;
   logic [7:0]  awaddr, araddr, product_out;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [11:0] data_in;
   logic [3:0]  mux_in;
   logic [3:0]  wstrb = 4'hF;
   int          fail_count = 0;
   int          n_tests = 0;
   int          cycles = 0;
   always #2.5 aclk = ~aclk;
   pld_fuse_and_matrix #(.FUSE_MAP(FMAP)) dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .data_in(data_in), .mux_in(mux_in), .product_out(product_out), .expr_out(expr_out),
      .mux_out(mux_out));
   // ****************************************
   // bus tasks and reporting
   // ****************************************
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do @(posedge aclk); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      // a late bready exercises the held response
      bready <= 1'($urandom);
      forever begin
         @(posedge aclk);
         if (bvalid === 1'b1 && bready === 1'b1) break;
         bready <= 1'b1;
      end
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'($urandom);
      forever begin
         @(posedge aclk);
         if (rvalid === 1'b1 && rready === 1'b1) break;
         rready <= 1'b1;
      end
      v = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         print_verdict();
      end
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      int          mode, sa, base, step, fr[8], ef[8];
      logic [1:0]  resp;
      logic [31:0] d;
      logic [7:0]  p;
      logic        e, m, x;
      void'($urandom(59));
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, data_in, mux_in} = '0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`STEP_OFFSET, d, resp);
      chk("step reset", 32'hC, d);
      rd(`FIRST_OFFSET + 8'h1C, d, resp);
      chk("first reset", 32'h0, d);
      wr(8'h20, 32'hFFFF_FFFF, resp);
      chk("bad write", 32'h2, 32'(resp));
      rd(8'h60, d, resp);
      chk("bad read", 32'h2, 32'(resp));
      chk("bad read data", 32'h0, d);
      // a single lane keeps the upper byte; control ignores a write without lane zero
      wr(`BASE_OFFSET, 32'h0000_1234, resp);
      wstrb <= 4'h1;
      wr(`BASE_OFFSET, 32'h0000_ABCD, resp);
      wstrb <= 4'h2;
      wr(`CTRL_OFFSET, 32'h0000_0011, resp);
      wstrb <= 4'hF;
      rd(`BASE_OFFSET, d, resp);
      chk("base lanes", 32'h0000_12CD, d);
      rd(`CTRL_OFFSET, d, resp);
      chk("ctrl lanes", 32'h0, d);
      // pass zero is the regular-numbering example; passes 1 to 3 take the pass number as mode, all else random
      for (int it = 0; it < 30; it++) begin
         mode = (it < 4) ? it : $urandom % 4;
         sa = (it == 0) ? 1 : $urandom % 2;
         base = (it == 0) ? 0 : $urandom % 200;
         step = (it == 0) ? 12 : $urandom % 30;
         wr(`CTRL_OFFSET, 32'(sa * 16 + mode), resp);
         wr(`BASE_OFFSET, 32'(base), resp);
         wr(`STEP_OFFSET, 32'(step), resp);
         chk("write resp", 32'h0, 32'(resp));
         for (int n = 0; n < 8; n++) begin
            fr[n] = $urandom % 250;
            ef[n] = sa ? base + n * step : fr[n];
            wr(`FIRST_OFFSET + 8'(4 * n), 32'(fr[n]), resp);
         end
         for (int n = 0; n < 8; n++) begin
            rd(`FIRST_OFFSET + 8'(4 * n), d, resp);
            chk("first fuse", 32'(ef[n]), d);
         end
         rd(`CTRL_OFFSET, d, resp);
         chk("ctrl", 32'(sa * 16 + mode), d);
         for (int k = 0; k < 4; k++) begin
            data_in <= 12'($urandom);
            mux_in <= 4'($urandom);
            repeat (3) @(posedge aclk);
            p = exp_prod(mode, ef, data_in);
            e = |(p & FMAP[967:960]) ^ FMAP[968];
            m = mux_in[{FMAP[1001], FMAP[1000]}] ^ FMAP[1023];
            chk("products", 32'(p), 32'(product_out));
            x = data_in[0] & data_in[2] & data_in[4] & data_in[8];
            if (it == 0) chk("example line", 32'(x), 32'(product_out[1]));
            chk("expression", 32'(e), 32'(expr_out));
            chk("selector", 32'(m), 32'(mux_out));
            rd(`STATUS_OFFSET, d, resp);
            chk("status", 32'({m, e, p}), d);
         end
      end
      print_verdict();
   end
endmodule
